// ---- hpcr_ctrl.sv ----
`timescale 1ns/1ps

// =========================================================
// Overview of operation
// - byte order one means first byte low
// - shared selector one enables shared access mode
// - shared selector zero in reset, one after
// - only core writes shared selector
// - host-to-core bit write-only, reads zero
// - host writing one raises core interrupt
// - host writing zero there does nothing
// - core writing one sets flag, pin low
// - core sets flag, host clears it
// - flag reads one while pin active low
// - host writing one clears; zero ignored
// - reset clears flag, pin high
// - host sees mirrored bytes, low four bits
// - core sees sixteen bits, low four used
// - both selects low plus two bytes
module hpcr_ctrl (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire hpcr_pkg::hpcr_host_s host_req,
  output logic [7:0]             host_rdata,
  input  wire hpcr_pkg::hpcr_core_s core_req,
  output logic [15:0]            core_rdata,
  output logic                   byte_order_sel,
  output logic                   shared_access_mode,
  output logic                   host_to_core_irq,
  output logic                   core_to_host_irq_b
);
  import hpcr_pkg::*;

  logic byte_order_reg;
  logic shared_reg;
  logic c2h_reg;
  logic h2c_pulse_reg;
  logic rst_seen_reg;
  logic host_ctrl_wr;
  logic host_ctrl_rd;
  logic core_c2h_set;
  logic host_c2h_clr;

  // control register selected: both selects low
  // select decode
  assign host_ctrl_wr = host_req.wr && !host_req.sel_hi && !host_req.sel_lo;
  assign host_ctrl_rd = host_req.rd && !host_req.sel_hi && !host_req.sel_lo;

  // =========================================================
  // byte order selector, host-only
  // host-written byte order
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_order_reg <= HPCR_RST_BYTE_ORD;
    end else if (host_ctrl_wr) begin
      byte_order_reg <= host_req.wdata[HPCR_BIT_BYTE_ORD];
    end
  end

  // =========================================================
  // shared access selector: zero in reset, one after release
  // preset after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_reg <= HPCR_RST_SHARED;
    end else if (!rst_seen_reg) begin
      shared_reg <= HPCR_SHARED_AFTER;
    end else if (core_req.wr) begin
      shared_reg <= core_req.wdata[HPCR_BIT_SHARED];
    end
  end

  // =========================================================
  // host-to-core interrupt pulse
  // one raises core request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      h2c_pulse_reg <= 1'b0;
    end else begin
      h2c_pulse_reg <= host_ctrl_wr && host_req.wdata[HPCR_BIT_H2C_IRQ];
    end
  end

  // =========================================================
  // core-to-host flag; set wins over clear
  // core sets flag
  assign core_c2h_set = core_req.wr && core_req.wdata[HPCR_BIT_C2H_IRQ];
  assign host_c2h_clr = host_ctrl_wr && host_req.wdata[HPCR_BIT_C2H_IRQ];

  // set by core, clear by host
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      c2h_reg <= HPCR_RST_C2H_IRQ;
    end else if (core_c2h_set) begin
      c2h_reg <= 1'b1;
    end else if (host_c2h_clr) begin
      c2h_reg <= 1'b0;
    end
  end

  // =========================================================
  // read data
  // host byte mirrored, low four bits
  // host layout, zero at interrupt request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata <= 8'h00;
    end else if (host_ctrl_rd) begin
      host_rdata <= {4'h0, c2h_reg, 1'b0, shared_reg, byte_order_reg};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_rdata <= 16'h0000;
    end else if (core_req.rd) begin
      core_rdata <= {12'h000, c2h_reg, 1'b0, shared_reg, 1'b0};
    end
  end

  // =========================================================
  // outputs
  assign byte_order_sel     = byte_order_reg;
  assign shared_access_mode = shared_reg;
  assign host_to_core_irq   = h2c_pulse_reg;
  assign core_to_host_irq_b = !c2h_reg;

  // =========================================================
  // assertions: reset and shared selector
  // preset after release
  a_shared_preset: assert property (@(posedge core_clk) disable iff (!rst_b)
    !rst_seen_reg |=> shared_reg)
    else $error("shared selector not one after reset");

  a_reset_values: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b)
    |-> (core_to_host_irq_b && !shared_access_mode && !host_to_core_irq
      && host_rdata == 8'h00 && core_rdata == 16'h0000))
    else $error("outputs not at reset values after release");

  a_shared_host_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rst_seen_reg && !core_req.wr) |=> $stable(shared_reg))
    else $error("shared selector changed without core write");

  a_shared_core_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.wr && rst_seen_reg
    |=> shared_access_mode == $past(core_req.wdata[HPCR_BIT_SHARED]))
    else $error("shared selector write lost");

  // =========================================================
  // assertions: byte order and select decode
  // host write only
  a_byte_order_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
    !host_ctrl_wr |=> $stable(byte_order_sel))
    else $error("byte order changed without host write");

  a_bo_host_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_wr
    |=> byte_order_sel == $past(host_req.wdata[HPCR_BIT_BYTE_ORD]))
    else $error("byte order write lost");

  a_bo_core_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.wr && !host_ctrl_wr
    |=> $stable(byte_order_sel))
    else $error("byte order changed by core write");

  a_select_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_req.wr && (host_req.sel_hi || host_req.sel_lo)
    |=> ($stable(byte_order_sel) && !host_to_core_irq))
    else $error("write with other select acted on control");

  // =========================================================
  // assertions: interrupts
  // one raises request
  a_h2c_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    (host_ctrl_wr && host_req.wdata[HPCR_BIT_H2C_IRQ]) |=> host_to_core_irq)
    else $error("host-to-core request missing");

  a_h2c_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(host_ctrl_wr && host_req.wdata[HPCR_BIT_H2C_IRQ]) |=> !host_to_core_irq)
    else $error("spurious host-to-core request");

  a_c2h_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_c2h_set |=> !core_to_host_irq_b)
    else $error("interrupt pin not low after core set");

  a_c2h_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (host_c2h_clr && !core_c2h_set) |=> core_to_host_irq_b)
    else $error("interrupt pin not released after host clear");

  a_c2h_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!core_c2h_set && !host_c2h_clr) |=> $stable(core_to_host_irq_b))
    else $error("flag changed without cause");

  a_c2h_no_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    !core_c2h_set
    |=> !$fell(core_to_host_irq_b))
    else $error("flag set without core write");

  a_c2h_no_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    !host_c2h_clr
    |=> !$rose(core_to_host_irq_b))
    else $error("flag cleared without host write");

  a_c2h_zero_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_wr && !host_req.wdata[HPCR_BIT_C2H_IRQ] && !core_c2h_set
    |=> $stable(core_to_host_irq_b))
    else $error("host zero write changed flag");

  // =========================================================
  // assertions: read data
  // host byte layout
  a_host_layout: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_rd |=> (host_rdata[2] == 1'b0 && host_rdata[3] == !$past(core_to_host_irq_b)
      && host_rdata[0] == $past(byte_order_reg)))
    else $error("host read layout wrong");

  a_host_h2c_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_rd
    |=> !host_rdata[HPCR_BIT_H2C_IRQ])
    else $error("host read of request bit not zero");

  a_host_c2h_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_rd
    |=> host_rdata[HPCR_BIT_C2H_IRQ] == !$past(core_to_host_irq_b))
    else $error("host read of flag wrong");

  a_host_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_rd
    |=> host_rdata[7:4] == 4'h0)
    else $error("host read upper bits not zero");

  a_host_shared_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_ctrl_rd
    |=> host_rdata[HPCR_BIT_SHARED] == $past(shared_access_mode))
    else $error("host read of shared selector wrong");

  a_host_rd_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !host_ctrl_rd
    |=> $stable(host_rdata))
    else $error("host read data changed without read");

  a_core_layout: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.rd |=> (core_rdata[15:4] == 12'h000 && core_rdata[1] == $past(shared_reg)))
    else $error("core read layout wrong");

  a_core_h2c_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.rd
    |=> !core_rdata[HPCR_BIT_H2C_IRQ])
    else $error("core read of request bit not zero");

  a_core_bo_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.rd
    |=> !core_rdata[HPCR_BIT_BYTE_ORD])
    else $error("core read shows byte order");

  a_core_c2h_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    core_req.rd
    |=> core_rdata[HPCR_BIT_C2H_IRQ] == !$past(core_to_host_irq_b))
    else $error("core read of flag wrong");

  a_core_rd_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !core_req.rd
    |=> $stable(core_rdata))
    else $error("core read data changed without read");

endmodule

// ---- hpcr_pkg.sv ----
package hpcr_pkg;

  // =========================================================
  // register select codes (register_select_hi, register_select_lo)
  localparam logic [1:0] HPCR_SEL_CTRL     = 2'h0;

  // =========================================================
  // bit positions inside each byte / core word
  localparam int         HPCR_BIT_BYTE_ORD = 32'h0;
  localparam int         HPCR_BIT_SHARED   = 32'h1;
  localparam int         HPCR_BIT_H2C_IRQ  = 32'h2;
  localparam int         HPCR_BIT_C2H_IRQ  = 32'h3;

  // =========================================================
  // reset values
  localparam logic       HPCR_RST_BYTE_ORD = 1'b0;
  localparam logic       HPCR_RST_SHARED   = 1'b0;
  localparam logic       HPCR_RST_C2H_IRQ  = 1'b0;
  localparam logic       HPCR_SHARED_AFTER = 1'b1;

  // =========================================================
  // host strobe group
  typedef struct packed {
    logic       sel_hi;
    logic       sel_lo;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } hpcr_host_s;

  // core strobe group
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } hpcr_core_s;

endpackage

// ---- hpcr_host_model.sv ----
`timescale 1ns/1ps

// =========================================================
// host processor: two-byte control register accesses
module hpcr_host_model (
  input  wire logic            core_clk,
  output hpcr_pkg::hpcr_host_s host_req
);
  import hpcr_pkg::*;
  // idle: deselected, data left wandering
  initial host_req = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
  task automatic access(input logic wr, input logic [7:0] b);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      #1;
      host_req = '{1'b0, 1'b0, wr, !wr, b};
    end
    @(posedge core_clk);
    #1;
    host_req = '{1'b1, 1'b1, 1'b0, 1'b0, ~b};
  endtask
  // one write strobe with another register selected
  task automatic stray(input logic [7:0] b);
    @(posedge core_clk);
    #1;
    host_req = '{1'b1, 1'b0, 1'b1, 1'b0, b};
    @(posedge core_clk);
    #1;
    host_req = '{1'b1, 1'b1, 1'b0, 1'b0, ~b};
  endtask
endmodule

// ---- hpcr_ctrl_bench.sv ----
`timescale 1ns/1ps

// =========================================================
// bench top
module hpcr_ctrl_bench;
  import hpcr_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b;
  hpcr_host_s  host_req;
  hpcr_core_s  core_req = '0;
  logic [7:0]  host_rdata;
  logic [15:0] core_rdata;
  logic        bo_o, sh_o, h2c, c2h_b, bo, sh, fl;
  int          n_mismatch = 0, num_checks = 0, np = 0, seed = 73473;
  logic [19:0] tbl [8] = '{20'h20008, 20'h10000, 20'h30000, 20'h0000A,
                           20'h20001, 20'h10000, 20'h00005, 20'h30000};

  always #20 core_clk = ~core_clk;
  // counts host-to-core pulses
  always @(posedge core_clk) if (h2c === 1'b1) np++;

  hpcr_host_model host (.core_clk(core_clk), .host_req(host_req));
  hpcr_ctrl uut (.core_clk(core_clk), .rst_b(rst_b), .host_req(host_req),
    .host_rdata(host_rdata), .core_req(core_req), .core_rdata(core_rdata),
    .byte_order_sel(bo_o), .shared_access_mode(sh_o),
    .host_to_core_irq(h2c), .core_to_host_irq_b(c2h_b));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // core strobe, then release with changed data
  task automatic cop(input logic wr, input logic [15:0] w);
    @(posedge core_clk);
    #1;
    core_req = '{wr, !wr, w};
    @(posedge core_clk);
    #1;
    core_req = '{1'b0, 1'b0, ~w};
  endtask

  // expected read values from the bench's own state
  function automatic logic [15:0] host_exp();
    return {8'h00, 4'h0, fl, 1'b0, sh, bo};
  endfunction

  function automatic logic [15:0] core_exp();
    return {12'h000, fl, 1'b0, sh, 1'b0};
  endfunction

  // hold reset, check reset values, release, check the preset
  task automatic reset_seq(input int cycles);
    rst_b = 1'b0;
    repeat (cycles) @(posedge core_clk);
    #1;
    check(sh_o, 16'h0);
    check(c2h_b, 16'h1);
    rst_b = 1'b1;
    {bo, sh, fl} = 3'b010;
    repeat (2) @(posedge core_clk);
    #1;
    check(sh_o, 16'h1);
  endtask

  // one operation, expectation update and checks
  task automatic op(input logic [1:0] k, input logic [15:0] w);
    case (k)
      2'h0: begin
        np = 0;
        host.access(1'b1, w[7:0]);
        @(posedge core_clk);
        #1;
        check(np[15:0], {14'h0, w[2], 1'b0});
        bo = w[0];
        fl = fl & !w[3];
      end
      2'h1: begin
        host.access(1'b0, w[7:0]);
        check(host_rdata, host_exp());
      end
      2'h2: begin
        cop(1'b1, w);
        fl = fl | w[3];
        sh = w[1];
      end
      default: begin
        cop(1'b0, w);
        check(core_rdata, core_exp());
      end
    endcase
    check(bo_o, bo);
    check(sh_o, sh);
    check(c2h_b, !fl);
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // =========================================================
  // main sequence: reset, corners, then random
  initial begin
    reset_seq(10);
    foreach (tbl[i]) op(tbl[i][17:16], tbl[i][15:0]);
    // flag and shared set, a write to another register, then a mid-run reset
    op(2'h2, 16'h000A);
    np = 0;
    host.stray(8'h0E);
    @(posedge core_clk);
    #1;
    check(np[15:0], 16'h0000);
    check(bo_o, bo);
    check(c2h_b, !fl);
    reset_seq(2);
    repeat (80) op($random(seed), $random(seed));
    results();
  end

  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule
